// ===== pkg/sadc_params.svh
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH

// ------------------------------------------------------------
// Register indices and byte addresses
// ------------------------------------------------------------
`define SADC_IDX_RESULT 8'h4e
`define SADC_IDX_CTRL 8'h4f
`define SADC_IDX_WIDTH 8

// ------------------------------------------------------------
// Control register field positions
// ------------------------------------------------------------
`define SADC_BIT_DONE 7
`define SADC_BIT_RC 6
`define SADC_BIT_ON 5
`define SADC_BIT_RSVD 4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SADC_CTRL_RESET 8'h00
`define SADC_RESULT_RESET 8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SADC_CONV_CYCLES 32
`define SADC_SAMPLE_CYCLES 12
`define SADC_CLK_HZ 10000000
`define SADC_MIN_OP_HZ 1000000

`endif

// ===== pkg/sadc_pkg.sv
package sadc_pkg;

    // Converter sequencer states
    typedef enum logic [1:0] {
        SADC_IDLE,
        SADC_SAMPLE,
        SADC_APPROX,
        SADC_FINISH
    } sadc_state_t;

    // Analog front-end controls
    typedef struct packed {
        logic sample_close;
        logic [3:0] mux_sel;
        logic [7:0] dac_code;
        logic comp_on;
        logic rc_osc_on;
    } sadc_afe_t;

    // Wishbone request bundle
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
    } sadc_wb_req_t;

endpackage

// ===== core/sadc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for the comparator decision
module sadc_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);

    logic meta_reg;

    // Only the second stage reads the first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// ===== core/sadc_tick.sv
`timescale 1ns/1ps
`default_nettype none

// Conversion clock tick: bus clock or resynchronised RC clock
module sadc_tick (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic use_rc_i,
    input wire logic rc_clk_i,
    output logic tick_o
);

    logic rc_meta_reg;
    logic rc_sync_reg;
    logic rc_prev_reg;

    // Sample RC clock into bus domain, detect rising edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_meta_reg <= 1'b0;
            rc_sync_reg <= 1'b0;
            rc_prev_reg <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            rc_meta_reg <= rc_clk_i;
            rc_sync_reg <= rc_meta_reg;
            rc_prev_reg <= rc_sync_reg;
            tick_o <= use_rc_i ? (rc_sync_reg & ~rc_prev_reg) : 1'b1;
        end
    end

endmodule

`default_nettype wire

// ===== core/sadc_ctrl.sv
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "sadc_params.svh"

module sadc_ctrl #(
    parameter int CONV_CYCLES = `SADC_CONV_CYCLES,
    parameter int SAMPLE_CYCLES = `SADC_SAMPLE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Power modes and clocks
    input wire logic stop_mode_i,
    input wire logic wait_mode_i,
    input wire logic rc_clk_i,
    // Analog front end
    input wire logic comparator_i,
    output logic sample_close_o,
    output logic [3:0] channel_select_o,
    output logic [7:0] dac_code_o,
    output logic converter_power_on_o,
    output logic rc_osc_on_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sadc_pkg::sadc_state_t state_reg;
    sadc_pkg::sadc_wb_req_t req;
    logic rc_clock_select_reg;
    logic converter_power_on_reg;
    logic [3:0] channel_select_reg;
    logic done_reg;
    logic [7:0] adc_result_reg;
    logic [7:0] sar_reg;
    logic [7:0] trial_reg;
    logic [5:0] cyc_cnt_reg;
    logic [3:0] samp_cnt_reg;
    logic tick;
    logic comp_sync;
    logic access;
    logic ctrl_wr;
    logic result_rd;
    logic finish;
    logic [7:0] ctrl_view;

    // Address decode shared by read and write paths
    function automatic logic hits(input logic [7:0] adr, input logic [7:0] idx);
        hits = (adr == idx);
    endfunction

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    // Operating clock selection
    sadc_tick u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .use_rc_i(rc_clock_select_reg),
        .rc_clk_i(rc_clk_i),
        .tick_o(tick)
    );

    // Comparator resynchronised
    sadc_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(comparator_i),
        .q_o(comp_sync)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i};
    assign access = req.cyc & req.stb & ~wb_ack_o;
    assign ctrl_wr = access & req.we & req.sel[0] & hits(req.adr, `SADC_IDX_CTRL);
    assign result_rd = access & ~req.we & hits(req.adr, `SADC_IDX_RESULT);
    assign finish = (state_reg == sadc_pkg::SADC_FINISH);
    assign ctrl_view = {done_reg, rc_clock_select_reg, converter_power_on_reg, 1'b0, channel_select_reg};

    // Single-wait-state ack and read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= access;
            if (access && !req.we) begin
                if (hits(req.adr, `SADC_IDX_CTRL))
                    wb_dat_o <= {24'h00_0000, ctrl_view};
                else if (hits(req.adr, `SADC_IDX_RESULT))
                    wb_dat_o <= {24'h00_0000, adc_result_reg};
                else
                    wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_clock_select_reg <= 1'b0;
            converter_power_on_reg <= 1'b0;
            channel_select_reg <= 4'h0;
        end else if (ctrl_wr) begin
            rc_clock_select_reg <= req.dat[`SADC_BIT_RC];
            converter_power_on_reg <= req.dat[`SADC_BIT_ON];
            channel_select_reg <= req.dat[3:0];
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    // Wait mode does not affect it; stop mode and power-off abort it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= sadc_pkg::SADC_IDLE;
            cyc_cnt_reg <= 6'h00;
            samp_cnt_reg <= 4'h0;
            sar_reg <= 8'h00;
            trial_reg <= 8'h80;
        end else if (stop_mode_i || !converter_power_on_reg) begin
            state_reg <= sadc_pkg::SADC_IDLE;
        end else if (ctrl_wr) begin
            state_reg <= sadc_pkg::SADC_IDLE;
        end else begin
            case (state_reg)
                sadc_pkg::SADC_IDLE: begin
                    state_reg <= sadc_pkg::SADC_SAMPLE;
                    cyc_cnt_reg <= 6'h00;
                    samp_cnt_reg <= 4'h0;
                    sar_reg <= 8'h00;
                    trial_reg <= 8'h80;
                end
                sadc_pkg::SADC_SAMPLE: begin
                    // Ticks are not counted here: all 32 go to the eight bit trials
                    samp_cnt_reg <= samp_cnt_reg + 4'h1;
                    if (samp_cnt_reg == 4'(SAMPLE_CYCLES - 1))
                        state_reg <= sadc_pkg::SADC_APPROX;
                end
                sadc_pkg::SADC_APPROX: begin
                    if (tick) begin
                        cyc_cnt_reg <= cyc_cnt_reg + 6'h01;
                        if (trial_reg != 8'h00 && cyc_cnt_reg[1:0] == 2'b11) begin
                            // Keep bit when input above DAC; top input gives ff
                            if (comp_sync)
                                sar_reg <= sar_reg | trial_reg;
                            trial_reg <= trial_reg >> 1;
                        end
                        if (cyc_cnt_reg == 6'(CONV_CYCLES - 1))
                            state_reg <= sadc_pkg::SADC_FINISH;
                    end
                end
                sadc_pkg::SADC_FINISH: begin
                    state_reg <= sadc_pkg::SADC_IDLE;
                end
                default: state_reg <= sadc_pkg::SADC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Result and done flag
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adc_result_reg <= `SADC_RESULT_RESET;
        end else if (finish && !ctrl_wr && !stop_mode_i && converter_power_on_reg) begin
            adc_result_reg <= sar_reg;
        end
    end

    // Set beats a read-clear; a control write always clears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_reg <= 1'b0;
        end else if (ctrl_wr) begin
            done_reg <= 1'b0;
        end else if (finish && !stop_mode_i && converter_power_on_reg) begin
            done_reg <= 1'b1;
        end else if (result_rd) begin
            done_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Analog front-end outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_close_o <= 1'b0;
            channel_select_o <= 4'h0;
            dac_code_o <= 8'h00;
            converter_power_on_o <= 1'b0;
            rc_osc_on_o <= 1'b0;
        end else begin
            sample_close_o <= (state_reg == sadc_pkg::SADC_SAMPLE) && !stop_mode_i;
            channel_select_o <= channel_select_reg;
            dac_code_o <= sar_reg | trial_reg;
            converter_power_on_o <= converter_power_on_reg & ~stop_mode_i;
            rc_osc_on_o <= rc_clock_select_reg & ~stop_mode_i;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_reset_clear;
        @(posedge clk_i) rst_i |=> !done_reg && !converter_power_on_reg && !rc_clock_select_reg;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left state set");

    property p_write_clears;
        @(posedge clk_i) disable iff (rst_i) ctrl_wr |=> !done_reg && state_reg == sadc_pkg::SADC_IDLE;
    endproperty
    a_write_clears: assert property (p_write_clears) else $error("write did not abort");

    property p_done_load;
        @(posedge clk_i) disable iff (rst_i)
            finish && !ctrl_wr && !stop_mode_i && converter_power_on_reg |=> done_reg && adc_result_reg == $past(sar_reg);
    endproperty
    a_done_load: assert property (p_done_load) else $error("result not loaded");

    property p_read_clear;
        @(posedge clk_i) disable iff (rst_i) result_rd && !finish && !ctrl_wr |=> !done_reg;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear done");

    property p_restart;
        @(posedge clk_i) disable iff (rst_i)
            finish && !ctrl_wr && !stop_mode_i && converter_power_on_reg |=> ##1 state_reg == sadc_pkg::SADC_SAMPLE;
    endproperty
    a_restart: assert property (p_restart) else $error("no automatic restart");

    property p_stop;
        @(posedge clk_i) disable iff (rst_i) stop_mode_i |=> state_reg == sadc_pkg::SADC_IDLE && !sample_close_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not halt");

    property p_off_no_done;
        @(posedge clk_i) disable iff (rst_i) !converter_power_on_reg && !done_reg && !ctrl_wr |=> !done_reg;
    endproperty
    a_off_no_done: assert property (p_off_no_done) else $error("done set while off");

    property p_bit4_zero;
        @(posedge clk_i) disable iff (rst_i) wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `SADC_IDX_CTRL |-> wb_dat_o[4] == 1'b0;
    endproperty
    a_bit4_zero: assert property (p_bit4_zero) else $error("bit four not zero");

    property p_sample_len;
        @(posedge clk_i) disable iff (rst_i || stop_mode_i || ctrl_wr || !converter_power_on_reg)
            $rose(state_reg == sadc_pkg::SADC_SAMPLE)
            |-> (state_reg == sadc_pkg::SADC_SAMPLE) [*8] ##0 1'b1;
    endproperty
    a_sample_len: assert property (p_sample_len) else $error("sample window short");

    property p_conv_len;
        @(posedge clk_i) disable iff (rst_i || stop_mode_i || ctrl_wr || !converter_power_on_reg || rc_clock_select_reg)
            state_reg == sadc_pkg::SADC_SAMPLE ##1 state_reg == sadc_pkg::SADC_APPROX
            |-> ##32 state_reg == sadc_pkg::SADC_FINISH;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

    c_done: cover property (@(posedge clk_i) disable iff (rst_i) $rose(done_reg));
    c_abort: cover property (@(posedge clk_i) disable iff (rst_i) ctrl_wr && state_reg == sadc_pkg::SADC_APPROX);
    c_rc: cover property (@(posedge clk_i) disable iff (rst_i) finish && rc_clock_select_reg);
    c_wait: cover property (@(posedge clk_i) disable iff (rst_i) finish && wait_mode_i);

endmodule

`default_nettype wire

// ===== sim/sadc_afe_model.sv
`timescale 1ns/1ps
`default_nettype none

// Analog mux, sample capacitor and comparator
module sadc_afe_model (
    input wire logic clk_i,
    input wire logic sample_close_i,
    input wire logic [3:0] channel_select_i,
    input wire logic [7:0] dac_code_i,
    input wire logic power_on_i,
    input wire logic [143:0] levels_i,
    output logic comparator_o
);
    int held = 0;
    logic flip = 1'b0;

    // Input followed only while the switch is closed, then held
    always @(posedge clk_i) begin
        flip <= ~flip;
        if (sample_close_i) begin
            held <= int'(levels_i[channel_select_i * 9 +: 9]); // Mux
        end
    end

    // Half-LSB offset avoids ties; over-range input wins every trial
    always_comb begin
        if (!power_on_i || channel_select_i inside {[4'h8:4'hb]}) begin
            comparator_o = flip;
        end else begin
            comparator_o = (2 * held + 1) > (2 * int'(dac_code_i));
        end
    end
endmodule

`default_nettype wire

// ===== sim/sar_adc_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sar_adc_controller_tb;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic stop_m = 0, wait_m = 0, rc_clk = 0, rc_run = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, samp, prev, pwr, rco, comp;
    logic [3:0] chs;
    logic [7:0] dac;
    logic [143:0] levels;
    logic [31:0] lfsr = 32'h7f47;
    int error_cnt = 0, check_count = 0, n, k;

    // Bus clock and RC clock, which runs only while rc_run is set
    always #50 clk_i = ~clk_i;
    always #333 rc_clk = rc_run & ~rc_clk;
    always @(posedge clk_i) prev <= samp;

    sadc_ctrl #(.CONV_CYCLES(32), .SAMPLE_CYCLES(12)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .stop_mode_i(stop_m), .wait_mode_i(wait_m), .rc_clk_i(rc_clk), .comparator_i(comp),
        .sample_close_o(samp), .channel_select_o(chs), .dac_code_o(dac),
        .converter_power_on_o(pwr), .rc_osc_on_o(rco)
    );

    sadc_afe_model afe (
        .clk_i(clk_i), .sample_close_i(samp), .channel_select_i(chs), .dac_code_i(dac),
        .power_on_i(pwr), .levels_i(levels), .comparator_o(comp)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected code: level clipped at full scale
    function automatic logic [31:0] expc(input int ch);
        logic [8:0] v;
        v = levels[ch * 9 +: 9];
        return (v > 9'h0ff) ? 32'h0000_00ff : {23'h0, v};
    endfunction

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task report_and_stop;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task run_out;
        error_cnt++;
        $display("[ERR] %0t wait ran out", $time);
        report_and_stop();
    endtask

    // Classic single cycle, held until ack sampled
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int m;
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        sel <= 4'hf;
        m = 0;
        do begin
            @(posedge clk_i);
            m++;
        end while (wb_ack_o !== 1'b1 && m < 20);
        if (m >= 20) run_out();
        rd = wb_dat_o;
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask

    // Poll done flag
    task wait_done(input int bound);
        int m;
        m = 0;
        do begin
            bus(0, 8'h4f, 8'h00);
            m++;
        end while (rd[7] !== 1'b1 && m < bound);
        if (m >= bound) run_out();
    endtask

    task to_rise(output int c);
        c = 0;
        do begin
            @(posedge clk_i);
            c++;
        end while (!(samp === 1'b1 && prev === 1'b0) && c < 500);
        if (c >= 500) run_out();
    endtask

    // Start, wait, read result and status
    task conv(input logic [7:0] ctl, input int bound);
        bus(1, 8'h4f, ctl);
        wait_done(bound);
        bus(0, 8'h4e, 8'h00);
        chk(rd, expc(ctl[3:0])); // Result
        bus(0, 8'h4f, 8'h00);
        chk(rd, {24'h0, 1'b0, ctl[6:5], 1'b0, ctl[3:0]}); // Status
    endtask

    initial begin
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            levels[i * 9 +: 9] = lfsr[8:0];
        end
        levels[12 * 9 +: 9] = 9'h1ff;
        levels[13 * 9 +: 9] = 9'h07f;
        levels[14 * 9 +: 9] = 9'h000;
        levels[2 * 9 +: 9] = 9'h011;
        levels[5 * 9 +: 9] = 9'h0ee;
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        chk({30'h0, pwr, rco}, 32'h0); // Outputs off
        bus(0, 8'h4f, 8'h00);
        chk(rd, 32'h0); // Status cleared
        // Oscillator only, converter off
        bus(1, 8'h4f, 8'h55);
        @(posedge clk_i);
        chk({30'h0, pwr, rco}, 32'h1); // Clock select
        repeat (80) @(posedge clk_i);
        bus(0, 8'h4f, 8'h00);
        chk(rd, 32'h45); // No done while off
        // Channel codes 0-7 and 12-15, wait mode random
        for (int i = 0; i < 16; i++) begin
            if (i < 8 || i > 11) begin
                lfsr = lfsr_next(lfsr);
                wait_m <= lfsr[0];
                conv(8'h30 | i[7:0], 40); // Sweep
            end
        end
        wait_m <= 0;
        // Sample window and period
        to_rise(n);
        k = 1;
        repeat (15) begin
            @(posedge clk_i);
            if (samp === 1'b1) k++;
        end
        chk(k, 12); // Window
        to_rise(n);
        chk(15 + n, 46); // Period
        // Continuous restart picks up new level
        @(posedge clk_i);
        levels[15 * 9 +: 9] <= 9'h0a5;
        bus(0, 8'h4e, 8'h00);
        wait_done(40);
        bus(0, 8'h4e, 8'h00);
        wait_done(40);
        bus(0, 8'h4e, 8'h00);
        chk(rd, 32'ha5); // Restart
        // Abort mid-conversion
        bus(1, 8'h4f, 8'h22);
        wait_done(40);
        repeat (20) @(posedge clk_i);
        bus(1, 8'h4f, 8'h25);
        bus(0, 8'h4f, 8'h00);
        chk(rd, 32'h25); // Done cleared
        wait_done(40);
        bus(0, 8'h4e, 8'h00);
        chk(rd, expc(5)); // New channel
        // Stop mode abandons conversion
        to_rise(n);
        bus(0, 8'h4e, 8'h00);
        repeat (17) @(posedge clk_i);
        stop_m <= 1;
        repeat (100) @(posedge clk_i);
        chk({31'h0, pwr}, 32'h0); // Halted
        bus(0, 8'h4f, 8'h00);
        chk(rd, 32'h25); // No done
        stop_m <= 0;
        wait_done(40);
        // RC conversion clock
        rc_run <= 1;
        conv(8'h63, 200); // RC
        chk({30'h0, pwr, rco}, 32'h3); // Both on
        bus(1, 8'h4f, 8'h00); // Both bits cleared
        rc_run <= 0;
        // Read-only result and unmapped place
        bus(1, 8'h4e, 8'haa);
        bus(0, 8'h4e, 8'h00);
        chk(rd, expc(3)); // Read only
        bus(0, 8'h10, 8'h00);
        chk(rd, 32'h0); // Unmapped
        report_and_stop();
    end
endmodule

`default_nettype wire
